// ### fopc_flash_ctrl.sv
// flash option, protection, clock divider and backdoor key control
// assumes bus-clock regs port; nonvolatile bytes stable around reset
`timescale 1ns/1ps
`include "fopc_regs.svh"

module fopc_flash_ctrl
	import fopc_pkg::*;
#(
	parameter int ADDR_W = 16
)
(
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              clkEn,
	input  wire logic [3:0]        regAddr,
	input  wire logic [7:0]        regWrData,
	input  wire logic              regWr,
	input  wire logic              regRd,
	output logic      [7:0]        regRdData,
	input  wire logic [7:0]        nvOptionByte,
	input  wire logic [7:0]        nvProtectByte,
	input  wire logic [63:0]       storedBackdoorKey,
	input  wire logic              debugAccess,
	input  wire logic              blankCheckPass,
	input  wire logic              keyRangeWrite,
	input  wire logic [2:0]        keyRangeIndex,
	input  wire logic [7:0]        keyRangeData,
	input  wire logic [ADDR_W-1:0] checkAddr,
	output logic                   flashClkTick,
	output logic                   progEraseEnable,
	output logic                   addrProtected,
	output logic                   commandStart,
	output logic                   secure,
	output logic                   unsecuredBlocked,
	output logic                   vectorRedirectDisable
);

	fopc_byte_t optionShadow;
	fopc_byte_t protectionRegister;
	fopc_byte_t configRegister;
	logic [5:0] clockDivisor;
	logic       prescaleByEight;
	logic       divisorLoadedFlag;
	logic       loadPending;
	logic       keyUnsecured;
	logic       blankUnsecured;
	logic       debugWriteEn;
	logic [2:0] preCount;
	logic [5:0] divCount;
	logic [2:0] keyIndex;
	logic       preTick;
	logic       keyWrite;
	logic       keyByteOk;
	logic [7:0] keyByteMatch;
	genvar      gi;
	logic       sec2Unsecured;
	fopc_key_e  keyState;
	fopc_byte_t next_regRdData;
	logic [ADDR_W-1:0] protectBoundary;

	// capture nonvolatile bytes on the first enabled edge after release
	// one cycle late so the nonvolatile read has settled after reset
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			loadPending <= 1'b1;
		else if (clkEn)
			loadPending <= 1'b0;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			optionShadow <= 8'h00;
		else if (clkEn && loadPending)
			optionShadow <= nvOptionByte & `FOPC_OPT_MASK;
		// no write path exists to this register
	end

	// config bits 7 to 5 only
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			configRegister <= 8'h00;
		else if (clkEn && regWr && regAddr == `FOPC_OFS_CONFIG)
			configRegister <= regWrData & `FOPC_CFG_MASK;
	end

	// debug-path write permission bit held by the system
	// reset clears it, so protection starts locked against writes
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			debugWriteEn <= 1'b0;
		else if (clkEn && regWr && regAddr == `FOPC_OFS_CONTROL)
			debugWriteEn <= regWrData[`FOPC_CTRL_DEBUG_BIT];
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			protectionRegister <= 8'h00;
		else if (clkEn && loadPending)
			protectionRegister <= nvProtectByte;
		else if (clkEn && regWr && regAddr == `FOPC_OFS_PROTECT
			&& debugWriteEn)
		begin
			// bit 0 has no write path, so protection never relaxes
			// only tighten when active
			if (!protectionRegister[0])
			begin
				if (regWrData[7:1] < protectionRegister[7:1])
					protectionRegister[7:1] <= regWrData[7:1];
			end
		end
	end

	// first write only
	// later writes drop silently; no error flag here
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			divisorLoadedFlag <= 1'b0;
			prescaleByEight   <= 1'b0;
			clockDivisor      <= 6'h00;
		end
		else if (clkEn && regWr && regAddr == `FOPC_OFS_DIVIDER
			&& !divisorLoadedFlag)
		begin
			divisorLoadedFlag <= 1'b1;
			prescaleByEight   <= regWrData[`FOPC_DIV_PRESCALE_BIT];
			clockDivisor      <= regWrData[5:0];
		end
	end

	// divide-by-eight prescaler
	// held at zero until loading, so the first tick after loading is aligned to the load
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			preCount <= 3'h0;
		else if (clkEn && divisorLoadedFlag)
			preCount <= (preCount == `FOPC_PRESCALE_COUNT) ? 3'h0
				: preCount + 3'h1;
	end

	assign preTick = !prescaleByEight || preCount == `FOPC_PRESCALE_COUNT;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			divCount     <= 6'h00;
			flashClkTick <= 1'b0;
		end
		else if (clkEn)
		begin
			flashClkTick <= 1'b0;
			if (divisorLoadedFlag && preTick)
			begin
				if (divCount >= clockDivisor)
				begin
					divCount     <= 6'h00;
					flashClkTick <= 1'b1;
				end
				else
					divCount <= divCount + 6'h01;
			end
		end
	end

	// debug accesses never feed the comparator
	assign keyWrite = keyRangeWrite && !debugAccess
		&& configRegister[`FOPC_CFG_KEYWR_BIT];
	assign keyByteOk = keyRangeIndex == keyIndex
		&& keyByteMatch[keyIndex];

	// one comparator per key byte, picked by the running index
	generate
		for (gi = 0; gi < `FOPC_KEY_BYTES; gi++)
		begin : g_keyByte
			assign keyByteMatch[gi] = keyRangeData
				== storedBackdoorKey[gi*8 +: 8];
		end
	endgenerate

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			keyState     <= FOPC_KEY_IDLE;
			keyIndex     <= 3'h0;
		end
		else if (clkEn)
		begin
			case (keyState)
				FOPC_KEY_IDLE,
				FOPC_KEY_COLL,
				FOPC_KEY_FAIL:
				begin
					if (keyWrite)
					begin
						keyIndex <= keyIndex + 3'h1;
						if (!keyByteOk)
							keyState <= FOPC_KEY_FAIL;
						else if (keyState != FOPC_KEY_FAIL)
							keyState <= FOPC_KEY_COLL;
						if (keyIndex == 3'h7)
							keyState <= FOPC_KEY_IDLE;
					end
					else if (!configRegister[`FOPC_CFG_KEYWR_BIT])
					begin
						keyIndex <= 3'h0;
						keyState <= FOPC_KEY_IDLE;
					end
				end
				default:
					keyState <= FOPC_KEY_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			keyUnsecured <= 1'b0;
		else if (clkEn && keyWrite && keyIndex == 3'h7 && keyByteOk
			&& keyState != FOPC_KEY_FAIL
			&& optionShadow[`FOPC_OPT_BACKDOOR_BIT])
			keyUnsecured <= 1'b1;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			blankUnsecured <= 1'b0;
		else if (clkEn && blankCheckPass)
			blankUnsecured <= 1'b1;
	end

	// only 1:0 unsecured
	// shadow keeps its loaded code; unlock flags override it
	assign sec2Unsecured = optionShadow[1:0] == `FOPC_SEC_UNSECURED
		|| keyUnsecured || blankUnsecured;

	assign protectBoundary = ADDR_W'({protectionRegister[7:1],
		{(`FOPC_GRANULE_SHIFT){1'b1}}});

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			secure <= 1'b1;
		else if (clkEn)
			secure <= !sec2Unsecured;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			unsecuredBlocked <= 1'b0;
		else if (clkEn)
			unsecuredBlocked <= !sec2Unsecured && debugAccess;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			vectorRedirectDisable <= 1'b0;
		else if (clkEn)
			vectorRedirectDisable <= optionShadow[`FOPC_OPT_NORED_BIT];
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			progEraseEnable <= 1'b0;
		else if (clkEn)
			progEraseEnable <= divisorLoadedFlag;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			addrProtected <= 1'b0;
		else if (clkEn)
			addrProtected <= !protectionRegister[0]
				&& checkAddr > protectBoundary;
	end

	// cleared key enable starts a command
	// debug writes start commands too; gating lies elsewhere
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			commandStart <= 1'b0;
		else if (clkEn)
			commandStart <= keyRangeWrite
				&& !configRegister[`FOPC_CFG_KEYWR_BIT];
	end

	always_comb
	begin
		next_regRdData = 8'h00;
		if (regAddr == `FOPC_OFS_DIVIDER)
			next_regRdData = {divisorLoadedFlag, prescaleByEight,
				clockDivisor};
		else if (regAddr == `FOPC_OFS_OPTION)
			next_regRdData = optionShadow;
		else if (regAddr == `FOPC_OFS_CONFIG)
			next_regRdData = configRegister;
		else if (regAddr == `FOPC_OFS_PROTECT)
			next_regRdData = protectionRegister;
		else if (regAddr == `FOPC_OFS_STATUS)
			next_regRdData = {5'h00, keyUnsecured, blankUnsecured,
				!sec2Unsecured};
		else if (regAddr == `FOPC_OFS_CONTROL)
			next_regRdData = {6'h00, debugWriteEn, 1'b0};
	end

	// read data valid only the cycle after the strobe
	// zero when idle so stale contents never reach the bus
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			regRdData <= 8'h00;
		else if (clkEn)
			regRdData <= regRd ? next_regRdData : 8'h00;
	end

endmodule : fopc_flash_ctrl

// ### fopc_flash_ctrl_monitor.sv
// assertion checker for the flash option and protection control block
// assumes single bus clock; bound to the design after the module
`timescale 1ns/1ps
`include "fopc_regs.svh"
module fopc_flash_ctrl_monitor
(
	input wire logic       clk,
	input wire logic       rst,
	input wire logic [3:0] regAddr,
	input wire logic       regRd,
	input wire logic [7:0] regRdData,
	input wire logic       debugAccess,
	input wire logic       blankCheckPass,
	input wire logic       keyRangeWrite,
	input wire logic       flashClkTick,
	input wire logic       progEraseEnable,
	input wire logic       commandStart,
	input wire logic       secure,
	input wire logic       unsecuredBlocked
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	chk_opt_zeros: assert property (
		$past(regRd && regAddr == `FOPC_OFS_OPTION) |-> regRdData[5:2] == 4'h0)
		else $error("option shadow unused bits set");
	chk_cfg_zeros: assert property (
		$past(regRd && regAddr == `FOPC_OFS_CONFIG) |-> regRdData[4:0] == 5'h00)
		else $error("config low bits set");
	chk_blocked_off: assert property (
		!secure && $past(!secure) |-> !unsecuredBlocked)
		else $error("blocked while unsecured");
	chk_blocked_on: assert property (
		secure && $past(secure) && debugAccess && $past(debugAccess)
		|-> unsecuredBlocked)
		else $error("debug not blocked while secure");
	chk_secure_sticky: assert property (!secure |=> !secure)
		else $error("security returned without reset");
	chk_blank_unsec: assert property (blankCheckPass |-> ##[1:3] !secure)
		else $error("blank check did not unsecure");
	chk_cmd_cause: assert property (commandStart |-> $past(keyRangeWrite))
		else $error("command start without key range write");
	chk_loaded_sticky: assert property (
		progEraseEnable |=> progEraseEnable)
		else $error("divider loaded flag dropped");
	cover property ($fell(secure));
	cover property (commandStart);
	cover property (flashClkTick);
	cover property (secure && debugAccess ##1 unsecuredBlocked);
endmodule : fopc_flash_ctrl_monitor

bind fopc_flash_ctrl fopc_flash_ctrl_monitor fopc_flash_ctrl_monitor_i (
	.clk(clk), .rst(rst), .regAddr(regAddr), .regRd(regRd),
	.regRdData(regRdData), .debugAccess(debugAccess),
	.blankCheckPass(blankCheckPass), .keyRangeWrite(keyRangeWrite),
	.flashClkTick(flashClkTick), .progEraseEnable(progEraseEnable),
	.commandStart(commandStart), .secure(secure),
	.unsecuredBlocked(unsecuredBlocked)
);

// ### fopc_pkg.sv
// types shared by the flash option and protection control block
// assumes fopc_regs.svh for all numeric constants
package fopc_pkg;
	typedef enum logic [1:0]
	{
		FOPC_KEY_IDLE  = 2'b00,
		FOPC_KEY_COLL  = 2'b01,
		FOPC_KEY_FAIL  = 2'b10
	} fopc_key_e;
	typedef logic [7:0] fopc_byte_t;
endpackage : fopc_pkg

// ### fopc_regs.svh
// register offsets, field positions, masks and timing counts
// assumes inclusion by bare name from the design, the monitor and the testbench
`ifndef FOPC_REGS_SVH
`define FOPC_REGS_SVH

`define FOPC_OFS_DIVIDER   4'h0
`define FOPC_OFS_OPTION    4'h1
`define FOPC_OFS_CONFIG    4'h2
`define FOPC_OFS_PROTECT   4'h3
`define FOPC_OFS_STATUS    4'h4
`define FOPC_OFS_KEYDATA   4'h5
`define FOPC_OFS_CONTROL   4'h6

`define FOPC_DIV_LOADED_BIT   7
`define FOPC_DIV_PRESCALE_BIT 6
`define FOPC_OPT_BACKDOOR_BIT 7
`define FOPC_OPT_NORED_BIT    6
`define FOPC_CFG_KEYWR_BIT    5
`define FOPC_CFG_MASK         8'hE0
`define FOPC_OPT_MASK         8'hC3
`define FOPC_SEC_UNSECURED    2'h2
`define FOPC_PRESCALE_COUNT   3'h7
`define FOPC_KEY_BYTES        4'h8
`define FOPC_GRANULE_SHIFT    9
`define FOPC_CTRL_BLANK_BIT   0
`define FOPC_CTRL_DEBUG_BIT   1

`define FOPC_PULSE_MIN_NS     5000
`define FOPC_PULSE_MAX_NS     6700
`define FOPC_CLK_PERIOD_NS    10
`define FOPC_PULSE_MIN_CYC \
	((`FOPC_PULSE_MIN_NS + `FOPC_CLK_PERIOD_NS - 1) / `FOPC_CLK_PERIOD_NS)
`define FOPC_PULSE_MAX_CYC (`FOPC_PULSE_MAX_NS / `FOPC_CLK_PERIOD_NS)

`endif

// ### testbench.sv
// self-checking bench for the flash option and protection control block
// assumes the bound monitor; clkEn high except in the freeze check
`timescale 1ns/1ps
`include "fopc_regs.svh"
module testbench
	import fopc_pkg::*;
;
	logic        clk, rst, regWr, regRd, debugAccess, blankCheckPass;
	logic        clkEn;
	logic        keyRangeWrite, flashClkTick, progEraseEnable, addrProtected;
	logic        commandStart, secure, unsecuredBlocked, vectorRedirectDisable;
	logic [3:0]  regAddr;
	logic [2:0]  keyRangeIndex;
	fopc_byte_t  regWrData, regRdData, nvOptionByte, nvProtectByte;
	fopc_byte_t  keyRangeData, d;
	logic [15:0] checkAddr;
	logic [63:0] key = 64'h0123456789ABCDEF;
	int          n_fail = 0;
	int          check_count = 0;
	int          n;

	fopc_flash_ctrl fopc_flash_ctrl_i (.clk(clk), .rst(rst), .clkEn(clkEn),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .nvOptionByte(nvOptionByte),
		.nvProtectByte(nvProtectByte), .storedBackdoorKey(key),
		.debugAccess(debugAccess), .blankCheckPass(blankCheckPass),
		.keyRangeWrite(keyRangeWrite), .keyRangeIndex(keyRangeIndex),
		.keyRangeData(keyRangeData), .checkAddr(checkAddr),
		.flashClkTick(flashClkTick), .progEraseEnable(progEraseEnable),
		.addrProtected(addrProtected), .commandStart(commandStart),
		.secure(secure), .unsecuredBlocked(unsecuredBlocked),
		.vectorRedirectDisable(vectorRedirectDisable));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : report_and_stop

	task automatic chk(input fopc_byte_t g, input fopc_byte_t e);
		check_count++;
		if (g !== e)
		begin
			n_fail++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	task automatic reset_dut(input fopc_byte_t opt, input fopc_byte_t prot);
		nvOptionByte <= opt;
		nvProtectByte <= prot;
		rst <= 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : reset_dut

	task automatic wr(input logic [3:0] a, input fopc_byte_t v);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= v;
		@(posedge clk);
		regWr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output fopc_byte_t v);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1 v = regRdData;
	endtask : rd

	// one write per cycle, indices in order
	task automatic sendkey;
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk);
			keyRangeWrite <= 1'b1;
			keyRangeIndex <= i[2:0];
			keyRangeData <= key[8*i +: 8];
		end
		@(posedge clk);
		keyRangeWrite <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask : sendkey

	// bounded: a stuck divider must not hang the run
	task automatic period;
		n = 0;
		while (flashClkTick !== 1'b1 && n < 999)
		begin
			@(posedge clk);
			#1 n++;
		end
		n = 0;
		do
		begin
			@(posedge clk);
			#1 n++;
		end
		while (flashClkTick !== 1'b1 && n < 999);
		if (n >= 999)
		begin
			n_fail++;
			report_and_stop;
		end
	endtask : period

	task automatic prot_at(input logic [15:0] a, input logic e);
		@(posedge clk);
		checkAddr <= a;
		repeat (2) @(posedge clk);
		#1 chk({7'h0, addrProtected}, {7'h0, e});
	endtask : prot_at

	task automatic t_opt;
		for (int c = 0; c < 4; c++)
		begin
			reset_dut({c[0], c[1], 4'hF, c[1:0]}, 8'h80);
			rd(`FOPC_OFS_OPTION, d);
			chk(d, {c[0], c[1], 4'h0, c[1:0]});
			wr(`FOPC_OFS_OPTION, 8'h3C);
			rd(`FOPC_OFS_OPTION, d);
			chk(d, {c[0], c[1], 4'h0, c[1:0]});
			chk({7'h0, vectorRedirectDisable}, {7'h0, c[1]});
			chk({7'h0, secure}, {7'h0, c != 2});
		end
		wr(`FOPC_OFS_CONFIG, 8'hFF);
		rd(`FOPC_OFS_CONFIG, d);
		chk(d, 8'hE0);
		wr(`FOPC_OFS_CONFIG, 8'h1F);
		rd(`FOPC_OFS_CONFIG, d);
		chk(d, 8'h00);
		@(posedge clk);
		clkEn <= 1'b0;
		wr(`FOPC_OFS_CONFIG, 8'hFF);
		@(posedge clk);
		clkEn <= 1'b1;
		rd(`FOPC_OFS_CONFIG, d);
		chk(d, 8'h00);
		$display("option and config test done");
	endtask : t_opt

	task automatic t_div(input fopc_byte_t v, input int per);
		reset_dut(8'h02, 8'h80);
		chk({7'h0, progEraseEnable}, 8'h00);
		wr(`FOPC_OFS_DIVIDER, v);
		wr(`FOPC_OFS_DIVIDER, ~v);
		rd(`FOPC_OFS_DIVIDER, d);
		chk(d, {1'b1, v[6:0]});
		chk({7'h0, progEraseEnable}, 8'h01);
		period;
		chk(n[7:0], per[7:0]);
		chk(n[15:8], per[15:8]);
		$display("divider test done");
	endtask : t_div

	task automatic t_prot;
		reset_dut(8'h02, 8'h80);
		wr(`FOPC_OFS_PROTECT, 8'h40);
		rd(`FOPC_OFS_PROTECT, d);
		chk(d, 8'h80);
		wr(`FOPC_OFS_CONTROL, 8'h02);
		wr(`FOPC_OFS_PROTECT, 8'hA0);
		rd(`FOPC_OFS_PROTECT, d);
		chk(d, 8'h80);
		wr(`FOPC_OFS_PROTECT, 8'h40);
		rd(`FOPC_OFS_PROTECT, d);
		chk(d, 8'h40);
		prot_at(16'hFFFF, 1'b1);
		prot_at(16'h0000, 1'b0);
		prot_at(16'h4200, 1'b1);
		prot_at(16'h41FF, 1'b0);
		reset_dut(8'h02, 8'h81);
		wr(`FOPC_OFS_CONTROL, 8'h02);
		wr(`FOPC_OFS_PROTECT, 8'h40);
		rd(`FOPC_OFS_PROTECT, d);
		chk(d, 8'h81);
		prot_at(16'hFFFF, 1'b0);
		$display("protection test done");
	endtask : t_prot

	task automatic t_key(input fopc_byte_t nv, input fopc_byte_t e);
		reset_dut(nv, 8'h80);
		wr(`FOPC_OFS_CONFIG, 8'h20);
		@(posedge clk);
		debugAccess <= 1'b1;
		sendkey;
		chk({7'h0, secure}, 8'h01);
		chk({7'h0, unsecuredBlocked}, 8'h01);
		@(posedge clk);
		debugAccess <= 1'b0;
		sendkey;
		chk({7'h0, secure}, e);
		rd(`FOPC_OFS_STATUS, d);
		chk(d, {5'h00, ~e[0], 1'b0, e[0]});
		wr(`FOPC_OFS_CONFIG, 8'h00);
		@(posedge clk);
		keyRangeWrite <= 1'b1;
		keyRangeIndex <= 3'h0;
		@(posedge clk);
		keyRangeWrite <= 1'b0;
		#1 chk({7'h0, commandStart}, 8'h01);
		$display("key test done");
	endtask : t_key

	initial
	begin
		rst = 1'b1;
		clkEn = 1'b1;
		regWr = 1'b0;
		regRd = 1'b0;
		regAddr = 4'h0;
		regWrData = 8'h00;
		nvOptionByte = 8'h02;
		nvProtectByte = 8'h80;
		debugAccess = 1'b0;
		blankCheckPass = 1'b0;
		keyRangeWrite = 1'b0;
		keyRangeIndex = 3'h0;
		keyRangeData = 8'h00;
		checkAddr = 16'h0000;
		t_opt;
		t_div(8'h03, 4);
		t_div(8'h41, 16);
		t_div(8'h7E, 504);
		chk({7'h0, n >= `FOPC_PULSE_MIN_CYC && n <= `FOPC_PULSE_MAX_CYC},
			8'h01);
		t_prot;
		t_key(8'h80, 8'h00);
		t_key(8'h00, 8'h01);
		reset_dut(8'h00, 8'h80);
		@(posedge clk);
		blankCheckPass <= 1'b1;
		@(posedge clk);
		blankCheckPass <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk({7'h0, secure}, 8'h00);
		rd(`FOPC_OFS_STATUS, d);
		chk(d, 8'h02);
		$display("blank check test done");
		report_and_stop;
	end

	initial
	begin
		#500us;
		n_fail++;
		report_and_stop;
	end
endmodule : testbench
